// *** logic/soec_host.sv ***
// Purpose: block-write controller for the output enable link, AXI4-Lite slave
// Assumes: single outstanding AXI read and write; no clock stretching on link
// Notes: sends address, zero command, count, then up to three data bytes
`include "soec_consts.svh"
module soec_host (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [3:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [3:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  soec_if.host bus
);
  import soec_pkg::*;

  soec_pkg::soec_host_s q;
  soec_pkg::soec_host_s d;

  logic tick;
  logic busy;
  logic [2:0] last_byte;
  logic [7:0] cur_byte;
  logic [31:0] status_word;

  function automatic logic [7:0] byte_at(input logic [2:0] idx, input logic [1:0] cnt,
                                         input logic [23:0] data);
    case (idx)
      3'h0: byte_at = {`SOEC_SLAVE_ADDR, `SOEC_DIR_WRITE}; // RL3 RL22
      3'h1: byte_at = `SOEC_CMD_CODE; // RL6
      3'h2: byte_at = {6'h00, cnt}; // RL7
      3'h3: byte_at = data[7:0];
      3'h4: byte_at = data[15:8];
      3'h5: byte_at = data[23:16];
      default: byte_at = 8'h00;
    endcase
  endfunction

  assign tick = (q.qcnt == 8'h00);
  assign busy = (q.st != H_IDLE);
  assign last_byte = 3'h2 + {1'b0, q.cnt};
  assign cur_byte = byte_at(q.byteidx, q.cnt, q.data);
  assign status_word = {29'h0, q.done, q.nack, busy};

  assign bus.scl_host_out = 1'b0;
  assign bus.sda_host_out = 1'b0;
  assign bus.scl_host_oe = q.scl_oe;
  assign bus.sda_host_oe = q.sda_oe;

  always_comb
  begin
    d = q;
    d.sda_sync = {q.sda_sync[0], bus.sda};

    // AXI write: address and data may arrive in either order
    if (i_s_axi_awvalid && q.awready)
    begin
      d.aw_have = 1'b1;
      d.awaddr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && q.wready)
    begin
      d.w_have = 1'b1;
      d.wdata = i_s_axi_wdata;
    end
    if (q.bvalid && i_s_axi_bready)
    begin
      d.bvalid = 1'b0;
    end
    if (d.aw_have && d.w_have && !q.bvalid)
    begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `SOEC_RESP_OKAY;
      case (d.awaddr)
        `SOEC_HREG_CTRL:
        begin
          // a zero count is never sent; busy or zero-count starts are dropped
          if (d.wdata[`SOEC_CTRL_GO_BIT] && !busy && d.wdata[1:0] != 2'h0) // RL4
          begin
            d.cnt = d.wdata[1:0];
            d.st = H_START;
            d.phase = 2'h0;
            d.qcnt = 8'(`SOEC_QUARTER_CYC - 1);
            d.nack = 1'b0;
            d.done = 1'b0;
          end
        end
        `SOEC_HREG_DATA:
        begin
          // upper nibble of byte 0, lower of byte 1, low six of byte 2 sent as zero
          if (!busy)
          begin
            d.data = d.wdata[23:0] & {`SOEC_EXT_USED, `SOEC_HIGH_USED, `SOEC_LOW_USED}; // RL16 RL17
          end
        end
        `SOEC_HREG_STATUS:
        begin
          d.bresp = `SOEC_RESP_OKAY;
        end
        default:
        begin
          d.bresp = `SOEC_RESP_SLVERR;
        end
      endcase
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;

    // AXI read
    if (q.rvalid && i_s_axi_rready)
    begin
      d.rvalid = 1'b0;
    end
    if (i_s_axi_arvalid && q.arready)
    begin
      d.rvalid = 1'b1;
      d.rresp = `SOEC_RESP_OKAY;
      case (i_s_axi_araddr)
        `SOEC_HREG_CTRL: d.rdata = {30'h0, q.cnt};
        `SOEC_HREG_DATA: d.rdata = {8'h00, q.data};
        `SOEC_HREG_STATUS: d.rdata = status_word;
        default:
        begin
          d.rdata = 32'h0;
          d.rresp = `SOEC_RESP_SLVERR;
        end
      endcase
    end
    d.arready = !d.rvalid;

    // link engine: four quarter phases per bit, scl made by division
    if (q.st != H_IDLE)
    begin
      if (!tick)
      begin
        d.qcnt = q.qcnt - 8'h01;
      end
      else
      begin
        d.qcnt = 8'(`SOEC_QUARTER_CYC - 1);
        d.phase = q.phase + 2'h1;
        case (q.st)
          H_START:
          begin
            if (q.phase == 2'h0) d.sda_oe = 1'b1;
            if (q.phase == 2'h2) d.scl_oe = 1'b1;
            if (q.phase == 2'h3)
            begin
              d.st = H_BIT;
              d.bitidx = 4'h0;
              d.byteidx = 3'h0;
            end
          end
          H_BIT:
          begin
            case (q.phase)
              2'h0:
              begin
                if (q.bitidx == `SOEC_BITS_PER_BYTE) d.sda_oe = 1'b0;
                else d.sda_oe = !cur_byte[3'(4'h7 - q.bitidx)]; // RL15
              end
              2'h1: d.scl_oe = 1'b0;
              2'h2:
              begin
                if (q.bitidx == `SOEC_BITS_PER_BYTE) d.nack = q.sda_sync[1]; // RL8
              end
              default:
              begin
                d.scl_oe = 1'b1;
                if (q.bitidx != `SOEC_BITS_PER_BYTE)
                begin
                  d.bitidx = q.bitidx + 4'h1;
                end
                else if (q.nack || q.byteidx == last_byte)
                begin
                  d.st = H_STOP; // RL2
                end
                else
                begin
                  d.bitidx = 4'h0;
                  d.byteidx = q.byteidx + 3'h1; // RL2
                end
              end
            endcase
          end
          H_STOP:
          begin
            if (q.phase == 2'h0) d.sda_oe = 1'b1;
            if (q.phase == 2'h1) d.scl_oe = 1'b0;
            if (q.phase == 2'h2) d.sda_oe = 1'b0;
            if (q.phase == 2'h3)
            begin
              d.st = H_IDLE;
              d.done = 1'b1;
            end
          end
          default: d.st = H_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      q <= '0;
    end
    else if (i_ce)
    begin
      q <= d;
    end
  end

  assign o_s_axi_awready = q.awready;
  assign o_s_axi_wready = q.wready;
  assign o_s_axi_bresp = q.bresp;
  assign o_s_axi_bvalid = q.bvalid;
  assign o_s_axi_arready = q.arready;
  assign o_s_axi_rdata = q.rdata;
  assign o_s_axi_rresp = q.rresp;
  assign o_s_axi_rvalid = q.rvalid;

endmodule // soec_host

// *** common/soec_consts.svh ***
// Purpose: constants of the output enable configuration link and its host
// Assumes: 100 MHz system clock, standard-mode serial link
// Notes: all timing counts are derived from the figures below
`ifndef SOEC_CONSTS_SVH
`define SOEC_CONSTS_SVH

// link framing
`define SOEC_SLAVE_ADDR 7'h69
`define SOEC_DIR_WRITE 1'b0
`define SOEC_CMD_CODE 8'h00
`define SOEC_MAX_COUNT 8'h20
`define SOEC_BITS_PER_BYTE 4'h8
`define SOEC_FIRST_DATA 6'h03
`define SOEC_BYTENUM_MAX 6'h3F

// configuration registers, offsets in data byte order
`define SOEC_REG_LOW_GROUP 6'h00
`define SOEC_REG_HIGH_GROUP 6'h01
`define SOEC_REG_EXT_GROUP 6'h02
`define SOEC_LOW_USED 8'h0F
`define SOEC_HIGH_USED 8'hF0
`define SOEC_EXT_USED 8'hC0
`define SOEC_ENABLE_RESET 8'h00

// host registers, byte addresses on AXI4-Lite
`define SOEC_HREG_CTRL 4'h0
`define SOEC_HREG_DATA 4'h4
`define SOEC_HREG_STATUS 4'h8
`define SOEC_CTRL_GO_BIT 8
`define SOEC_STATUS_BUSY_BIT 0
`define SOEC_STATUS_NACK_BIT 1
`define SOEC_STATUS_DONE_BIT 2
`define SOEC_RESP_OKAY 2'h0
`define SOEC_RESP_SLVERR 2'h2

// timing
`define SOEC_CLK_PERIOD_NS 10
`define SOEC_SCL_PERIOD_NS 10000
`define SOEC_QUARTER_CYC (`SOEC_SCL_PERIOD_NS / `SOEC_CLK_PERIOD_NS / 4)

`endif

// *** common/soec_pkg.sv ***
// Purpose: types shared by both ends of the configuration link
// Assumes: constants come from soec_consts.svh
// Notes: reset value of every state struct is all zeros
package soec_pkg;

  typedef enum logic [1:0] {D_IDLE, D_RX, D_ACK} soec_dev_e;

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} soec_host_e;

  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic [1:0] buf_sync;
    logic [1:0] oe_sync;
    logic [1:0] pd_sync;
    soec_dev_e st;
    logic [7:0] shift;
    logic [3:0] bitcnt;
    logic [5:0] bytenum;
    logic sda_oe;
    logic [7:0] en_low;
    logic [7:0] en_high;
    logic [7:0] en_ext;
    logic [9:0] fan;
    logic drive;
  } soec_dev_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_have;
    logic w_have;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [1:0] cnt;
    logic [23:0] data;
    logic nack;
    logic done;
    soec_host_e st;
    logic [7:0] qcnt;
    logic [1:0] phase;
    logic [3:0] bitidx;
    logic [2:0] byteidx;
    logic scl_oe;
    logic sda_oe;
    logic [1:0] sda_sync;
  } soec_host_s;

endpackage

// *** common/soec_if.sv ***
// Purpose: two-wire open-drain link between host and device
// Assumes: external pull-ups, modelled as a high level when nobody drives
// Notes: each oe high means that party pulls the line to its out value
interface soec_if;
  logic scl_host_out;
  logic scl_host_oe;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic scl;
  logic sda;

  assign scl = ~(scl_host_oe & ~scl_host_out);
  assign sda = ~((sda_host_oe & ~sda_host_out) | (sda_dev_oe & ~sda_dev_out));

  modport device (
    input scl,
    input sda,
    output sda_dev_out,
    output sda_dev_oe
  );

  modport host (
    input scl,
    input sda,
    output scl_host_out,
    output scl_host_oe,
    output sda_host_out,
    output sda_host_oe
  );
endinterface

// *** logic/soec_device.sv ***
// Purpose: serial slave receiver loading clock fanout output enables
// Assumes: bus pins, buffered clock and pin controls are asynchronous to i_clk
// Notes: receive only; it never answers a read and never stretches the clock
//
// Functional notes
// RL1 - only block writes configure the device
// RL2 - data stored ascending; partial transfers keep bytes
// RL3 - host sends address, command, count, data
// RL4 - count never zero, at most 32 bytes
// RL5 - device acknowledges every received byte low
// RL6 - host sends command code of zero
// RL7 - count excludes command and count, 1 to 32
// RL8 - transfer valid once count byte acknowledged
// RL9 - command and count contents are ignored
// RL10 - data bytes beyond defined ones discarded
// RL11 - never hold lines low; no stretching
// RL12 - general call address is not acknowledged
// RL13 - standard mode, no input glitch filter
// RL14 - power down releases lines, keeps registers
// RL15 - bytes in order, bits msb first
// RL16 - reserved bits ignored, host writes zero
// RL17 - host zeroes bits marked initialize zero
// RL18 - registers hold the last written value
// RL19 - byte 0 bits 3:0 enable outputs 3:0
// RL20 - byte 1 bits 7:4 enable outputs 15:12
// RL21 - disabled output held low, not switching
// RL22 - fixed address 1101001, direction treated write
// RL23 - byte 2 bits 7:6 enable outputs 17:16
// RL24 - enables static; disabled outputs low when driving
`include "soec_consts.svh"
module soec_device (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_power_down_mode_n,
  input wire logic i_buf_clock,
  input wire logic i_output_enable,
  soec_if.device bus,
  output logic [9:0] o_fanout_clock_out,
  output logic o_fanout_drive,
  output logic [7:0] o_enable_low,
  output logic [7:0] o_enable_high,
  output logic [7:0] o_enable_ext
);
  import soec_pkg::*;

  soec_pkg::soec_dev_s q;
  soec_pkg::soec_dev_s d;

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic addr_miss;
  logic [5:0] data_idx;
  logic [9:0] enable_vec;

  // edges come from the second and third stages; stage one feeds stage two only
  assign scl_rise = q.scl_sync[1] & ~q.scl_sync[2];
  assign scl_fall = ~q.scl_sync[1] & q.scl_sync[2];
  assign start_seen = q.scl_sync[1] & q.scl_sync[2] & ~q.sda_sync[1] & q.sda_sync[2];
  assign stop_seen = q.scl_sync[1] & q.scl_sync[2] & q.sda_sync[1] & ~q.sda_sync[2];

  // direction bit is not decoded: the device only ever receives
  assign addr_miss = (q.shift[7:1] != `SOEC_SLAVE_ADDR); // RL22 RL12

  assign data_idx = q.bytenum - `SOEC_FIRST_DATA;

  // output order: 17,16 from byte 2, 15..12 from byte 1, 3..0 from byte 0
  assign enable_vec = {q.en_ext[7:6], q.en_high[7:4], q.en_low[3:0]}; // RL19 RL20 RL23

  // open drain: only the enable ever changes, the driven level is always low
  assign bus.sda_dev_out = 1'b0;
  assign bus.sda_dev_oe = q.sda_oe;

  always_comb
  begin
    d = q;
    // plain three-stage sampling of the bus lines, no spike filter needed in standard mode
    d.scl_sync = {q.scl_sync[1:0], bus.scl}; // RL13
    d.sda_sync = {q.sda_sync[1:0], bus.sda}; // RL13
    d.buf_sync = {q.buf_sync[0], i_buf_clock};
    d.oe_sync = {q.oe_sync[0], i_output_enable};
    d.pd_sync = {q.pd_sync[0], i_power_down_mode_n};

    // enables drive the output stage as static levels
    d.fan = {10{q.buf_sync[1]}} & enable_vec; // RL21 RL24
    d.drive = q.oe_sync[1]; // RL24

    if (!q.pd_sync[1])
    begin
      // power down: let go of the data line, keep all programmed enables
      d.st = D_IDLE; // RL14
      d.sda_oe = 1'b0; // RL14
      d.bitcnt = 4'h0;
    end
    else if (start_seen)
    begin
      // a repeated start simply begins a new block write
      d.st = D_RX; // RL1
      d.bitcnt = 4'h0;
      d.bytenum = 6'h00;
      d.sda_oe = 1'b0;
    end
    else if (stop_seen)
    begin
      // stopping after any whole byte leaves stored bytes in place
      d.st = D_IDLE; // RL2
      d.sda_oe = 1'b0;
    end
    else
    begin
      case (q.st)
        D_IDLE:
        begin
          d.sda_oe = 1'b0;
        end
        D_RX:
        begin
          if (scl_rise && q.bitcnt != `SOEC_BITS_PER_BYTE)
          begin
            d.shift = {q.shift[6:0], q.sda_sync[1]}; // RL15
            d.bitcnt = q.bitcnt + 4'h1;
          end
          else if (scl_fall && q.bitcnt == `SOEC_BITS_PER_BYTE)
          begin
            if (q.bytenum == 6'h00 && addr_miss)
            begin
              // not ours, general call included: stay off the bus until next start
              d.st = D_IDLE; // RL12
            end
            else
            begin
              // acknowledge address, command, count and data alike
              d.st = D_ACK; // RL5 RL8
              d.sda_oe = 1'b1; // RL5
              // command code and count are accepted but never examined
              if (q.bytenum >= `SOEC_FIRST_DATA) // RL9
              begin
                case (data_idx)
                  `SOEC_REG_LOW_GROUP:
                  begin
                    d.en_low = q.shift; // RL2 RL18
                  end
                  `SOEC_REG_HIGH_GROUP:
                  begin
                    d.en_high = q.shift; // RL2 RL18
                  end
                  `SOEC_REG_EXT_GROUP:
                  begin
                    // reserved bits of byte 2 are not kept
                    d.en_ext = q.shift & `SOEC_EXT_USED; // RL23 RL16
                  end
                  default:
                  begin
                    // bytes past the defined ones are acknowledged and dropped
                    d.en_ext = q.en_ext; // RL10
                  end
                endcase
              end
            end
          end
        end
        D_ACK:
        begin
          // release on the falling edge that ends the ack bit, so the data
          // line is held for one whole bit and only changes while the clock is low
          if (scl_fall)
          begin
            d.sda_oe = 1'b0; // RL11
            d.bitcnt = 4'h0;
            d.st = D_RX;
            if (q.bytenum != `SOEC_BYTENUM_MAX)
            begin
              d.bytenum = q.bytenum + 6'h01;
            end
          end
        end
        default:
        begin
          d.st = D_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // enables clear at reset so every output starts disabled
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      q <= '0;
    end
    else if (i_ce)
    begin
      q <= d;
    end
  end

  // the registers are not readable over the link; these ports show them
  assign o_enable_low = q.en_low; // RL18
  assign o_enable_high = q.en_high; // RL18
  assign o_enable_ext = q.en_ext; // RL18
  assign o_fanout_clock_out = q.fan;
  assign o_fanout_drive = q.drive;

endmodule // soec_device

// *** dv/soec_properties.sv ***
// Purpose: wire-level checks on the two-wire link between host and device
// Assumes: lines sampled on i_clk; both ends are design modules
// Notes: bit and byte counts restart at every start condition
`include "soec_consts.svh"
module soec_properties (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_scl_host_oe,
  input wire logic i_sda_host_oe,
  input wire logic i_sda_dev_oe,
  input wire logic i_scl,
  input wire logic i_sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_q;
  logic [2:0] byte_q;
  logic [7:0] shf_q;
  logic [10:0] hold_q;
  logic [10:0] low_q;
  logic rise;
  logic start;
  logic stop;
  logic [7:0] cur;
  assign rise = i_scl & ~scl_q;
  assign start = i_scl & scl_q & sda_q & ~i_sda;
  assign stop = i_scl & scl_q & ~sda_q & i_sda;
  assign cur = {shf_q[6:0], i_sda};

  // lines idle high out of reset, so no false edge right after release
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_q <= 4'h0;
      byte_q <= 3'h0;
      shf_q <= 8'h00;
      hold_q <= 11'h000;
      low_q <= 11'h000;
    end
    else
    begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      hold_q <= i_sda_dev_oe ? hold_q + {10'h000, ~&hold_q} : 11'h000;
      low_q <= !i_scl ? low_q + {10'h000, ~&low_q} : 11'h000;
      if (start)
      begin
        bit_q <= 4'h0;
        byte_q <= 3'h0;
      end
      else if (rise)
      begin
        shf_q <= cur;
        bit_q <= (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
        if (bit_q == 4'h9 && byte_q != 3'h7)
          byte_q <= byte_q + 3'h1;
      end
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  dev_hold_limit_a: assert property (hold_q <= 11'h44C)
    else $error("device holds data line low too long");
  scl_low_bound_a: assert property (low_q <= 11'h320)
    else $error("clock line low longer than a standard-mode bit allows");
  ack_edge_safe_a: assert property ($changed(i_sda_dev_oe) |-> !i_scl)
    else $error("device moved data line while clock high");
  ack_slot_only_a: assert property (rise && bit_q != 4'h8 |-> !i_sda_dev_oe)
    else $error("device drives data line outside the ack bit");
  ack_by_device_a: assert property (rise && bit_q == 4'h8
    |-> !i_sda_host_oe && (i_sda || i_sda_dev_oe))
    else $error("ack bit not left to the device");
  addr_match_a: assert property (rise && bit_q == 4'h7 && byte_q == 3'h0
    |-> cur == {`SOEC_SLAVE_ADDR, `SOEC_DIR_WRITE})
    else $error("address byte wrong");
  cmd_zero_a: assert property (rise && bit_q == 4'h7 && byte_q == 3'h1
    |-> cur == `SOEC_CMD_CODE)
    else $error("command byte not zero");
  count_range_a: assert property (rise && bit_q == 4'h7 && byte_q == 3'h2
    |-> cur != 8'h00 && cur <= `SOEC_MAX_COUNT)
    else $error("byte count out of range");
  stop_whole_a: assert property (stop |-> bit_q == 4'h1)
    else $error("stop inside a byte");
endmodule // soec_properties

// *** dv/testbench.sv ***
// Purpose: host and device joined on one link, driven over AXI4-Lite
// Assumes: quarter bit of 250 clocks, so a full block write takes about 56k cycles
// Notes: three transfers: full write, write with device powered down, short write
`include "soec_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import soec_pkg::*;
  localparam int LIMIT = 120000;
  logic i_clk, i_nrst, pd_n, bufc, oe_pin;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, drive;
  logic [1:0] bresp, rresp, r;
  logic [9:0] fan;
  logic [7:0] en_lo, en_hi, en_ex;
  int error_cnt, checks, cyc;

  soec_if link();
  soec_host soec_host_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .bus(link));
  soec_device soec_device_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1),
    .i_power_down_mode_n(pd_n), .i_buf_clock(bufc), .i_output_enable(oe_pin),
    .bus(link), .o_fanout_clock_out(fan), .o_fanout_drive(drive),
    .o_enable_low(en_lo), .o_enable_high(en_hi), .o_enable_ext(en_ex));
  soec_properties soec_properties_inst (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_scl_host_oe(link.scl_host_oe), .i_sda_host_oe(link.sda_host_oe),
    .i_sda_dev_oe(link.sda_dev_oe), .i_scl(link.scl), .i_sda(link.sda));

  always #5 i_clk = ~i_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t: got %h, want %h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("mismatches %0d, comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // address and data offered together, each dropped at its own take
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge i_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw | w)
    begin
      @(posedge i_clk);
      awvalid <= aw & ~awready;
      wvalid <= w & ~wready;
      aw = aw & ~awready;
      w = w & ~wready;
    end
    while (bvalid !== 1'b1) @(posedge i_clk);
    chk(bresp, er);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge i_clk);
    while (arready !== 1'b1) @(posedge i_clk);
    arvalid <= 1'b0;
    @(posedge i_clk);
    while (rvalid !== 1'b1) @(posedge i_clk);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    rd(a, v, r);
    chk(v, e);
    chk(r, er);
  endtask

  // the host takes thousands of cycles per byte, so busy is polled, not timed
  task automatic poll;
    do rd(`SOEC_HREG_STATUS, v, r); while (v[`SOEC_STATUS_BUSY_BIT] !== 1'b0);
  endtask

  task automatic fan_chk(input logic b, input logic [9:0] e);
    @(posedge i_clk);
    bufc <= b;
    repeat (6) @(posedge i_clk);
    chk(fan, e);
  endtask

  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      error_cnt++;
      close_out;
    end
  end

  initial
  begin
    i_clk = 1'b0;
    i_nrst = 1'b0;
    pd_n = 1'b1;
    bufc = 1'b0;
    oe_pin = 1'b1;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk({en_ex, en_hi, en_lo}, 24'h000000);
    rdc(`SOEC_HREG_STATUS, 32'h0, `SOEC_RESP_OKAY);
    rdc(4'hC, 32'h0, `SOEC_RESP_SLVERR);
    wr(4'hC, 32'h1, `SOEC_RESP_SLVERR);
    wr(`SOEC_HREG_DATA, 32'h00FF5FFA, `SOEC_RESP_OKAY);
    rdc(`SOEC_HREG_DATA, 32'h00C0500A, `SOEC_RESP_OKAY);
    wr(`SOEC_HREG_CTRL, 32'h00000103, `SOEC_RESP_OKAY);
    rdc(`SOEC_HREG_STATUS, 32'h1, `SOEC_RESP_OKAY);
    wr(`SOEC_HREG_DATA, 32'h0, `SOEC_RESP_OKAY);
    wr(`SOEC_HREG_CTRL, 32'h00000101, `SOEC_RESP_OKAY);
    rdc(`SOEC_HREG_DATA, 32'h00C0500A, `SOEC_RESP_OKAY);
    poll();
    chk(v, 32'h4);
    chk(en_lo, 8'h0A);
    chk(en_hi, 8'h50);
    chk(en_ex, 8'hC0);
    // a zero count must never reach the link: go is dropped, done stays set
    wr(`SOEC_HREG_CTRL, 32'h00000100, `SOEC_RESP_OKAY);
    rdc(`SOEC_HREG_STATUS, 32'h4, `SOEC_RESP_OKAY);
    rdc(`SOEC_HREG_CTRL, 32'h3, `SOEC_RESP_OKAY);
    fan_chk(1'b1, 10'h35A);
    fan_chk(1'b0, 10'h000);
    chk(drive, 1'b1);
    oe_pin <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk(drive, 1'b0);
    oe_pin <= 1'b1;
    pd_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    wr(`SOEC_HREG_CTRL, 32'h00000101, `SOEC_RESP_OKAY);
    poll();
    chk(v, 32'h6);
    chk({en_ex, en_hi, en_lo}, 24'hC0500A);
    pd_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    wr(`SOEC_HREG_DATA, 32'h00000005, `SOEC_RESP_OKAY);
    wr(`SOEC_HREG_CTRL, 32'h00000101, `SOEC_RESP_OKAY);
    poll();
    chk(v, 32'h4);
    chk({en_ex, en_hi, en_lo}, 24'hC05005);
    rdc(`SOEC_HREG_CTRL, 32'h1, `SOEC_RESP_OKAY);
    close_out();
  end
endmodule // testbench
